// *** verilog/cim_pkg.sv ***
package cim_pkg;

    localparam int DI_NUM = 10;
    localparam int MC_NUM = 8;
    localparam int PT_BASE = 8;
    localparam int PT_WIDE_MAX = 16;
    localparam int PT_WIDE_STEP = 2;
    localparam int CFG_W = 4;
    localparam int ADR_W = 12;
    localparam int TERM_WORDS = 2;

    localparam logic [ADR_W-1:0] CFG_OFS = 12'h000;
    localparam logic [ADR_W-1:0] CTRL_OFS = 12'h080;
    localparam logic [ADR_W-1:0] PIN_OFS = 12'h084;
    localparam logic [ADR_W-1:0] Q_OFS = 12'h088;
    localparam logic [ADR_W-1:0] OE_OFS = 12'h08C;
    localparam logic [ADR_W-1:0] SUM_OFS = 12'h090;
    localparam logic [ADR_W-1:0] FUSE_OFS = 12'h400;

    localparam logic [CFG_W-1:0] CFG_RST = 4'h0;
    localparam logic CTRL_RUN_RST = 1'b0;
    localparam logic FUSE_RST = 1'b1;

    typedef enum logic [1:0] {FB_PIN, FB_REG, FB_SUM} cim_fb_t;

    typedef enum logic [2:0] {
        RG_NONE, RG_CFG, RG_CTRL, RG_PIN, RG_Q, RG_OE, RG_SUM, RG_FUSE
    } cim_reg_t;

    typedef struct packed {
        logic legal;
        logic out_reg;
        logic act_low;
        cim_fb_t fb;
    } cim_mode_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADR_W-1:0] adr;
        logic [31:0] dat;
    } cim_wb_req_t;

    // odd codes are active high, even codes active low
    function automatic cim_mode_t cim_decode(input logic [CFG_W-1:0] code);
        cim_mode_t m;
        m = '{legal: 1'b1, out_reg: 1'b0, act_low: ~code[0], fb: FB_PIN};
        case (code)
            4'h1, 4'h2: m.out_reg = 1'b1;
            4'h3, 4'h4: m.fb = FB_PIN;
            4'h5, 4'h6: begin
                m.out_reg = 1'b1;
                m.fb = FB_SUM;
            end
            // sum fed back ahead of enable
            4'h7, 4'h8: m.fb = FB_SUM;
            4'h9, 4'hA: begin
                m.out_reg = 1'b1;
                m.fb = FB_REG;
            end
            4'hB, 4'hC: m.fb = FB_REG;
            default: m.legal = 1'b0;
        endcase
        return m;
    endfunction

endpackage

// *** verilog/cim_pterm_sum.sv ***
`timescale 1ns/1ps
module cim_pterm_sum #(
    parameter int LINES = 36,
    parameter int TERMS = 8
) (
    input wire logic [LINES-1:0] lines_i,
    input wire logic [TERMS-1:0][LINES-1:0] fuse_i,
    input wire logic [TERMS-1:0] use_i,
    output logic sum_o
);
    import cim_pkg::*;

    // a fuse bit of one ties its line into the AND; all fuses set gives x & ~x
    always_comb begin
        sum_o = 1'b0;
        for (int t = 0; t < TERMS; t++) begin
            if (use_i[t] && (&(lines_i | ~fuse_i[t]))) begin
                sum_o = 1'b1;
            end
        end
    end

endmodule

// *** verilog/cim_macrocell.sv ***
`timescale 1ns/1ps
module cim_macrocell (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic aclr_i,
    input wire logic spre_i,
    input wire logic sum_i,
    input wire logic oe_term_i,
    input wire logic run_i,
    input wire logic [cim_pkg::CFG_W-1:0] cfg_i,
    input wire logic pin_i,
    output logic q_o,
    output logic pin_o,
    output logic pin_oe_o,
    output logic fb_o
);
    import cim_pkg::*;

    cim_mode_t mode;
    logic q_ff;
    logic nxt_q;

    always_comb begin
        mode = cim_decode(cfg_i);
        nxt_q = rst_i ? 1'b0 : (spre_i ? 1'b1 : sum_i);
    end

    always_ff @(posedge clk_i or posedge aclr_i) begin
        if (aclr_i) begin
            q_ff <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    always_comb begin
        pin_o = (mode.out_reg ? q_ff : sum_i) ^ mode.act_low;
        pin_oe_o = oe_term_i & run_i & mode.legal;
        unique case (mode.fb)
            FB_PIN: fb_o = pin_i;
            FB_REG: fb_o = q_ff;
            FB_SUM: fb_o = sum_i;
            default: fb_o = pin_i;
        endcase
    end

    assign q_o = q_ff;

endmodule

// *** verilog/cim_top.sv ***
`timescale 1ns/1ps
module cim_top #(
    parameter int DI_N = cim_pkg::DI_NUM,
    parameter int MC_N = cim_pkg::MC_NUM,
    parameter bit WIDE = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cim_pkg::cim_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [DI_N-1:0] ded_i,
    input wire logic [MC_N-1:0] pin_i,
    output logic [MC_N-1:0] pin_o,
    output logic [MC_N-1:0] pin_oe_o
);
    import cim_pkg::*;

    // array inputs are dedicated pins plus one feedback per macrocell
    localparam int IN_N = DI_N + MC_N;
    localparam int LINES = 2 * IN_N;
    localparam int PT_N = WIDE ? PT_WIDE_MAX : PT_BASE;
    localparam int TERMS_MC = PT_N + 1;
    localparam int SP_IDX = MC_N * TERMS_MC;
    localparam int AC_IDX = SP_IDX + 1;
    localparam int TERM_N = AC_IDX + 1;
    localparam int FW = 32 * TERM_WORDS;

    // fuse words are two per term, so at most 64 lines fit
    logic [LINES-1:0] fuse_ff [TERM_N];
    logic [LINES-1:0] nxt_fuse [TERM_N];
    logic [CFG_W-1:0] cfg_ff [MC_N];
    logic [CFG_W-1:0] nxt_cfg [MC_N];
    logic run_ff;
    logic nxt_run;
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;

    logic [LINES-1:0] lines;
    logic [MC_N-1:0] mc_fb;
    logic [MC_N-1:0] mc_sum;
    logic [MC_N-1:0] mc_oet;
    logic [MC_N-1:0] mc_q;
    logic sp_term;
    logic ac_term;

    logic req;
    logic wr_go;
    cim_reg_t rsel;
    logic [8:0] term_idx;
    logic term_half;

    // wide variant tapers from the middle towards both ends
    function automatic int pt_count(input int m);
        int d;
        d = (m < MC_N - 1 - m) ? m : MC_N - 1 - m;
        if (!WIDE) begin
            return PT_BASE;
        end
        if (PT_BASE + PT_WIDE_STEP * d > PT_WIDE_MAX) begin
            return PT_WIDE_MAX;
        end
        return PT_BASE + PT_WIDE_STEP * d;
    endfunction

    function automatic cim_reg_t reg_decode(input logic [ADR_W-1:0] a);
        logic [ADR_W-1:0] off;
        off = a - FUSE_OFS;
        if (a >= FUSE_OFS) begin
            if (int'(off[ADR_W-1:3]) < TERM_N) begin
                return RG_FUSE;
            end
            return RG_NONE;
        end
        if (a < CTRL_OFS) begin
            if (int'(a[ADR_W-1:2]) < MC_N) begin
                return RG_CFG;
            end
            return RG_NONE;
        end
        case (a)
            CTRL_OFS: return RG_CTRL;
            PIN_OFS: return RG_PIN;
            Q_OFS: return RG_Q;
            OE_OFS: return RG_OE;
            SUM_OFS: return RG_SUM;
            default: return RG_NONE;
        endcase
    endfunction

    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ---- bus slave: one wait state, ack for exactly one cycle ----

    assign req = wb_req_i.cyc & wb_req_i.stb;
    // write lands on the edge where the master sees ack
    assign wr_go = req & wb_req_i.we & ack_ff;

    always_comb begin
        logic [ADR_W-1:0] foff;
        logic [FW-1:0] fword;
        foff = wb_req_i.adr - FUSE_OFS;
        rsel = reg_decode(wb_req_i.adr);
        term_idx = foff[ADR_W-1:3];
        term_half = foff[2];
        fword = '0;
        fword[LINES-1:0] = fuse_ff[int'(term_idx) % TERM_N];
        nxt_ack = req & ~ack_ff;
        nxt_rdat = rdat_ff;
        if (nxt_ack) begin
            nxt_rdat = 32'h0000_0000;
            unique case (rsel)
                RG_CFG: nxt_rdat = 32'(cfg_ff[int'(wb_req_i.adr[ADR_W-1:2]) % MC_N]);
                RG_CTRL: nxt_rdat = 32'(run_ff);
                RG_PIN: nxt_rdat = 32'(pin_i);
                RG_Q: nxt_rdat = 32'(mc_q);
                RG_OE: nxt_rdat = 32'(pin_oe_o);
                RG_SUM: nxt_rdat = 32'(mc_sum);
                RG_FUSE: nxt_rdat = fword[32*term_half +: 32];
                RG_NONE: nxt_rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // ---- configuration store ----

    always_comb begin
        logic [FW-1:0] w;
        logic [31:0] cw;
        nxt_run = run_ff;
        for (int m = 0; m < MC_N; m++) begin
            nxt_cfg[m] = cfg_ff[m];
        end
        for (int t = 0; t < TERM_N; t++) begin
            nxt_fuse[t] = fuse_ff[t];
        end
        w = '0;
        cw = 32'h0000_0000;
        if (wr_go) begin
            unique case (rsel)
                RG_CFG: begin
                    cw = 32'(cfg_ff[int'(wb_req_i.adr[ADR_W-1:2]) % MC_N]);
                    cw = lane_merge(cw, wb_req_i.dat, wb_req_i.sel);
                    nxt_cfg[int'(wb_req_i.adr[ADR_W-1:2]) % MC_N] = cw[CFG_W-1:0];
                end
                RG_CTRL: begin
                    cw = lane_merge(32'(run_ff), wb_req_i.dat, wb_req_i.sel);
                    nxt_run = cw[0];
                end
                RG_FUSE: begin
                    w[LINES-1:0] = fuse_ff[int'(term_idx)];
                    w[32*term_half +: 32] =
                        lane_merge(w[32*term_half +: 32], wb_req_i.dat, wb_req_i.sel);
                    nxt_fuse[int'(term_idx)] = w[LINES-1:0];
                end
                RG_PIN, RG_Q, RG_OE, RG_SUM, RG_NONE: nxt_run = run_ff;
            endcase
        end
    end

    // fuses come up all set, so every term is false and every pin floats
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_ff <= CTRL_RUN_RST;
            for (int m = 0; m < MC_N; m++) begin
                cfg_ff[m] <= CFG_RST;
            end
            for (int t = 0; t < TERM_N; t++) begin
                fuse_ff[t] <= {LINES{FUSE_RST}};
            end
        end else begin
            run_ff <= nxt_run;
            for (int m = 0; m < MC_N; m++) begin
                cfg_ff[m] <= nxt_cfg[m];
            end
            for (int t = 0; t < TERM_N; t++) begin
                fuse_ff[t] <= nxt_fuse[t];
            end
        end
    end

    // ---- array ----

    always_comb begin
        logic src;
        src = 1'b0;
        for (int k = 0; k < IN_N; k++) begin
            src = (k < DI_N) ? ded_i[k] : mc_fb[k-DI_N];
            lines[2*k] = src;
            lines[2*k+1] = ~src;
        end
    end

    cim_pterm_sum #(.LINES(LINES), .TERMS(1)) u_sp (
        .lines_i(lines),
        .fuse_i(fuse_ff[SP_IDX]),
        .use_i(1'b1),
        .sum_o(sp_term)
    );

    cim_pterm_sum #(.LINES(LINES), .TERMS(1)) u_ac (
        .lines_i(lines),
        .fuse_i(fuse_ff[AC_IDX]),
        .use_i(1'b1),
        .sum_o(ac_term)
    );

    genvar g;
    generate
        for (g = 0; g < MC_N; g++) begin : g_mc
            logic [PT_N-1:0][LINES-1:0] mfuse;
            logic [PT_N-1:0] muse;

            always_comb begin
                for (int p = 0; p < PT_N; p++) begin
                    mfuse[p] = fuse_ff[g*TERMS_MC + p];
                    // terms past this sum's share stay unused
                    muse[p] = (p < pt_count(g));
                end
            end

            // one sum, one macrocell, one pin
            cim_pterm_sum #(.LINES(LINES), .TERMS(PT_N)) u_sum (
                .lines_i(lines),
                .fuse_i(mfuse),
                .use_i(muse),
                .sum_o(mc_sum[g])
            );

            cim_pterm_sum #(.LINES(LINES), .TERMS(1)) u_oe (
                .lines_i(lines),
                .fuse_i(fuse_ff[g*TERMS_MC + PT_N]),
                .use_i(1'b1),
                .sum_o(mc_oet[g])
            );

            // each cell configured on its own
            cim_macrocell u_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .aclr_i(ac_term),
                .spre_i(sp_term),
                .sum_i(mc_sum[g]),
                .oe_term_i(mc_oet[g]),
                .run_i(run_ff),
                .cfg_i(cfg_ff[g]),
                .pin_i(pin_i[g]),
                .q_o(mc_q[g]),
                .pin_o(pin_o[g]),
                .pin_oe_o(pin_oe_o[g]),
                .fb_o(mc_fb[g])
            );

            property p_preset;
                @(posedge clk_i) disable iff (rst_i)
                (sp_term && !ac_term && !rst_i) ##1 !ac_term |-> mc_q[g];
            endproperty
            a_preset: assert property (p_preset) else $error("preset missed");

            property p_clear;
                @(posedge clk_i) disable iff (rst_i)
                ac_term |-> !mc_q[g];
            endproperty
            a_clear: assert property (p_clear) else $error("clear missed");

            property p_capture;
                @(posedge clk_i) disable iff (rst_i)
                (!sp_term && !ac_term && !rst_i) ##1 !ac_term |-> mc_q[g] == $past(mc_sum[g]);
            endproperty
            a_capture: assert property (p_capture) else $error("sum not captured");

            property p_float;
                @(posedge clk_i) disable iff (rst_i)
                (!mc_oet[g] || !run_ff) |-> !pin_oe_o[g];
            endproperty
            a_float: assert property (p_float) else $error("pin driven while off");

            property p_std;
                @(posedge clk_i) disable iff (rst_i)
                (cfg_ff[g] == 4'h9) |-> pin_o[g] == mc_q[g] && mc_fb[g] == mc_q[g];
            endproperty
            a_std: assert property (p_std) else $error("registered cell wrong");

            property p_pinfb;
                @(posedge clk_i) disable iff (rst_i)
                (cfg_ff[g] == 4'h2) |-> mc_fb[g] == pin_i[g] && pin_o[g] == !mc_q[g];
            endproperty
            a_pinfb: assert property (p_pinfb) else $error("pin feedback wrong");

            property p_buried;
                @(posedge clk_i) disable iff (rst_i)
                (cfg_ff[g] == 4'h7) |-> mc_fb[g] == mc_sum[g];
            endproperty
            a_buried: assert property (p_buried) else $error("buried sum lost");

            property p_sumreg;
                @(posedge clk_i) disable iff (rst_i)
                (cfg_ff[g] == 4'h5) |-> mc_fb[g] == mc_sum[g] && pin_o[g] == mc_q[g];
            endproperty
            a_sumreg: assert property (p_sumreg) else $error("sum with reg wrong");

            property p_regfb;
                @(posedge clk_i) disable iff (rst_i)
                (cfg_ff[g] == 4'hC) |-> mc_fb[g] == mc_q[g] && pin_o[g] == !mc_sum[g];
            endproperty
            a_regfb: assert property (p_regfb) else $error("buried reg wrong");
        end
    endgenerate

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

    property p_cfg_wr;
        @(posedge clk_i) disable iff (rst_i)
        (wr_go && wb_req_i.adr == CFG_OFS && wb_req_i.sel[0])
        |=> cfg_ff[0] == $past(wb_req_i.dat[CFG_W-1:0]);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");

    c_preset: cover property (@(posedge clk_i) disable iff (rst_i) sp_term ##1 mc_q[0]);
    c_clear: cover property (@(posedge clk_i) disable iff (rst_i) ac_term);
    c_drive: cover property (@(posedge clk_i) disable iff (rst_i) pin_oe_o[0] ##1 !pin_oe_o[0]);
    c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_go);

endmodule

// *** sim/cim_board_model.sv ***
`timescale 1ns/1ps
module cim_board_model #(
    parameter int N = 8
) (
    input wire logic [N-1:0] dev_val_i,
    input wire logic [N-1:0] dev_oe_i,
    input wire logic [N-1:0] ext_en_i,
    input wire logic [N-1:0] ext_val_i,
    output logic [N-1:0] wire_o
);
    // board side of each pin: device, outside driver or pull-up
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (dev_oe_i[i] && ext_en_i[i]) begin
                // contention is a board fault, shown as unknown
                wire_o[i] = 1'bx;
            end else if (dev_oe_i[i]) begin
                wire_o[i] = dev_val_i[i];
            end else if (ext_en_i[i]) begin
                wire_o[i] = ext_val_i[i];
            end else begin
                wire_o[i] = 1'b1;
            end
        end
    end
endmodule

// *** sim/tb_configurable_io_macrocell.sv ***
`timescale 1ns/1ps
module tb_configurable_io_macrocell;
    import cim_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cim_wb_req_t wb_req = '0;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic [DI_NUM-1:0] ded = '0;
    logic [MC_NUM-1:0] pin_wire;
    logic [MC_NUM-1:0] pin_val;
    logic [MC_NUM-1:0] pin_oe;
    logic [MC_NUM-1:0] ext_en = '0;
    logic [MC_NUM-1:0] ext_val = '0;
    int mismatches = 0;
    int check_count = 0;
    logic [31:0] rd_q[$];
    logic [5:0] pin_q[$];
    logic [5:0] note;
    event pin_evt;
    logic [3:0] code;
    logic d, e, legal, al, rg, pv, fb;

    cim_top DUT (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(wb_req),
        .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack),
        .ded_i(ded),
        .pin_i(pin_wire),
        .pin_o(pin_val),
        .pin_oe_o(pin_oe)
    );

    cim_board_model #(.N(MC_NUM)) board (
        .dev_val_i(pin_val),
        .dev_oe_i(pin_oe),
        .ext_en_i(ext_en),
        .ext_val_i(ext_val),
        .wire_o(pin_wire)
    );

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // classic single cycle, held until ack is seen
    task wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
            input logic [31:0] exp);
        int n;
        @(posedge clk_i);
        if (!we) rd_q.push_back(exp);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        n = 0;
        // ack is looked at on the rising edge where the write lands
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 100);
        if (wb_ack !== 1'b1) begin
            mismatches++;
            conclude();
        end else begin
            wb_req <= '0;
        end
    endtask

    // a term is two words; word one left empty
    task set_term(input int t, input logic [31:0] w);
        wb(1'b1, FUSE_OFS + 12'(8 * t), w, 32'h0);
        wb(1'b1, FUSE_OFS + 12'(8 * t + 4), 32'h0, 32'h0);
    endtask

    // sampled mid-cycle so the edge updates have landed
    task expect_pins(input logic [2:0] exp, input logic [2:0] mask);
        @(negedge clk_i);
        pin_q.push_back({mask, exp});
        -> pin_evt;
    endtask

    // read data taken at the same edge that sees ack
    always @(posedge clk_i) begin
        if (wb_ack === 1'b1 && !wb_req.we && rd_q.size() > 0) check(wb_dat, rd_q.pop_front());
    end

    // observed: enable of cell 0, value of cell 0, feedback of cell 0 via cell 1
    always begin
        @(pin_evt);
        note = pin_q.pop_front();
        check(32'({pin_oe[0], pin_val[0], pin_val[1]} & note[5:3]), 32'(note[2:0] & note[5:3]));
    end

    initial begin
        void'($urandom(53));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CTRL_OFS, 32'h0, 32'h0);
        wb(1'b1, 12'h0C0, 32'hFFFF_FFFF, 32'h0);
        wb(1'b0, 12'h0C0, 32'h0, 32'h0);
        wb(1'b1, Q_OFS, 32'hFFFF_FFFF, 32'h0);
        wb(1'b0, Q_OFS, 32'h0, 32'h0);
        wb(1'b0, OE_OFS, 32'h0, 32'h0);
        wb(1'b1, CFG_OFS, 32'hFFFF_FFF7, 32'h0);
        wb(1'b0, CFG_OFS, 32'h0, 32'h7);
        set_term(0, 32'h0000_0001);
        set_term(8, 32'h0004_0000);
        set_term(9, 32'h0010_0000);
        set_term(17, 32'h0);
        set_term(72, 32'h0001_0000);
        set_term(73, 32'h0000_4000);
        wb(1'b1, CFG_OFS + 12'h004, 32'h3, 32'h0);
        wb(1'b1, CTRL_OFS, 32'h1, 32'h0);
        for (int c = 0; c < 16; c++) begin
            code = 4'(c);
            d = 1'($urandom);
            e = 1'($urandom);
            legal = (code >= 4'h1 && code <= 4'hC);
            al = ~code[0];
            rg = code inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA};
            wb(1'b1, CFG_OFS, {28'h0, code}, 32'h0);
            @(posedge clk_i);
            ded[0] <= d;
            ded[9] <= 1'b1;
            ext_en[0] <= 1'b0;
            repeat (2) @(posedge clk_i);
            // register still holds old sum for one edge
            ded[0] <= ~d;
            pv = (rg ? d : ~d) ^ al;
            if (!legal) fb = 1'b1;
            else if (code <= 4'h4) fb = pv;
            else if (code <= 4'h8) fb = ~d;
            else fb = d;
            expect_pins({legal, pv, fb}, {1'b1, legal, 1'b1});
            @(posedge clk_i);
            ded[9] <= 1'b0;
            ext_en[0] <= 1'b1;
            ext_val[0] <= e;
            fb = (legal && code >= 4'h5) ? ~d : e;
            expect_pins({1'b0, ~d ^ al, fb}, {1'b1, legal, 1'b1});
        end
        wb(1'b1, CFG_OFS, 32'h1, 32'h0);
        @(posedge clk_i);
        ded[0] <= 1'b0;
        ded[9] <= 1'b1;
        ext_en[0] <= 1'b0;
        repeat (2) @(posedge clk_i);
        ded[8] <= 1'b1;
        expect_pins(3'b100, 3'b111);
        @(posedge clk_i);
        ded[8] <= 1'b0;
        expect_pins(3'b111, 3'b111);
        @(posedge clk_i);
        ded[0] <= 1'b1;
        repeat (2) @(posedge clk_i);
        ded[7] <= 1'b1;
        expect_pins(3'b100, 3'b111);
        @(posedge clk_i);
        ded[7] <= 1'b0;
        expect_pins(3'b100, 3'b111);
        @(posedge clk_i);
        expect_pins(3'b111, 3'b111);
        @(posedge clk_i);
        ext_en[2] <= 1'b1;
        wb(1'b0, Q_OFS, 32'h0, 32'h0000_0003);
        wb(1'b0, SUM_OFS, 32'h0, 32'h0000_0003);
        wb(1'b0, OE_OFS, 32'h0, 32'h0000_0003);
        wb(1'b0, PIN_OFS, 32'h0, 32'h0000_00FB);
        // mid-run reset must put back every store
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CFG_OFS, 32'h0, 32'(CFG_RST));
        wb(1'b0, CTRL_OFS, 32'h0, 32'(CTRL_RUN_RST));
        wb(1'b0, FUSE_OFS, 32'h0, 32'hFFFF_FFFF);
        wb(1'b0, FUSE_OFS + 12'h004, 32'h0, 32'h0000_000F);
        wb(1'b0, OE_OFS, 32'h0, 32'h0);
        wb(1'b0, Q_OFS, 32'h0, 32'h0);
        conclude();
    end
endmodule
